// >>> src/ptm_top.sv
// Pixel tone mapper: table mapping, tone correction, output buffer and APB registers
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Raw 10 bit pixels leave as 8 bits by dropping the two low bits when mapping is off.
// - A writable table holds 1024 entries, index 0 to 1023, of 10 bits each.
// - An even pixel uses the entry at its own index; the pixel path never reads odd entries.
// - An odd pixel takes the straight-line midpoint of the even entries below and above.
// - Pixel 1023 takes entry 1022 as it stands, with no interpolation.
// - With mapping on, the 10 bit mapped value is cut to its upper 8 bits.
// - Mapping acts only while the mapping enable is set; otherwise raw values pass.
// - The table selector only accepts the luminance table, and entry accesses go to it.
// - With tone correction on, output is the ceiling times (input over ceiling) to the exponent.
// - The ceiling is 255 for 8 bit output and 4095 for 12 bit output; the code has only the 8 bit output and uses 255.
// - An exponent of exactly 1 leaves every pixel unchanged.
// - Zero and full scale pass tone correction unchanged for any exponent.
// - Tone correction has its own enable and is fully bypassed while it is clear.
// - The exponent ranges from 0 to 3.99902 and is used as programmed.
module ptm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pix_in_valid,
    output logic             pix_in_ready,
    input  wire logic [9:0]  pix_in_data,
    output logic             pix_out_valid,
    input  wire logic        pix_out_ready,
    output logic [7:0]       pix_out_data
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // Position of the leading one of a nonzero byte
    function automatic logic [2:0] lead_one(input logic [7:0] x);
        logic [2:0] k;
        k = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (x[i]) begin
                k = 3'(i);
            end
        end
        lead_one = k;
    endfunction

    // Piecewise-linear log2 in Q3.7
    function automatic logic [9:0] log2_q(input logic [7:0] x);
        logic [2:0]  k;
        logic [14:0] sh;
        k      = lead_one(x);
        sh     = {7'h00, x} << (3'h7 - k);
        log2_q = {k, sh[6:0]};
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic                    map_enable;
    logic                    tone_enable;
    ptm_pkg::ptm_table_t     table_select;
    logic [9:0]              table_entry_index;
    logic [11:0]             tone_exponent;
    logic [31:0]             pixel_count;
    logic [9:0]              table_mem [ptm_pkg::TBL_DEPTH];

    logic                    apb_access;
    logic                    apb_wr;
    logic                    apb_mapped;

    assign apb_access = psel && penable;
    assign apb_wr     = apb_access && pwrite;
    assign apb_mapped = addr_hit(paddr, ptm_pkg::OFS_CTRL)     ||
                        addr_hit(paddr, ptm_pkg::OFS_SELECT)   ||
                        addr_hit(paddr, ptm_pkg::OFS_INDEX)    ||
                        addr_hit(paddr, ptm_pkg::OFS_VALUE)    ||
                        addr_hit(paddr, ptm_pkg::OFS_EXPONENT) ||
                        addr_hit(paddr, ptm_pkg::OFS_STATUS)   ||
                        addr_hit(paddr, ptm_pkg::OFS_COUNT);

    // Zero wait states keep the register path simple
    assign pready  = 1'b1;
    assign pslverr = apb_access && !apb_mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            map_enable  <= 1'b0;
            tone_enable <= 1'b0;
        end else if (apb_wr && addr_hit(paddr, ptm_pkg::OFS_CTRL)) begin
            map_enable  <= pwdata[ptm_pkg::CTRL_MAP_EN];
            tone_enable <= pwdata[ptm_pkg::CTRL_TONE_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_select <= ptm_pkg::SELECT_RESET;
        end else if (apb_wr && addr_hit(paddr, ptm_pkg::OFS_SELECT)) begin
            case (pwdata[1:0])
                ptm_pkg::PTM_TBL_LUMINANCE: table_select <= ptm_pkg::PTM_TBL_LUMINANCE;
                default:           table_select <= table_select;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_entry_index <= 10'h000;
        end else if (apb_wr && addr_hit(paddr, ptm_pkg::OFS_INDEX)) begin
            table_entry_index <= pwdata[9:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tone_exponent <= ptm_pkg::EXP_RESET;
        end else if (apb_wr && addr_hit(paddr, ptm_pkg::OFS_EXPONENT)) begin
            tone_exponent <= pwdata[11:0];
        end
    end

    // writes reach the selected table
    // No reset on the table: it is a memory, and software loads it before enabling
    always_ff @(posedge pclk) begin
        if (apb_wr && addr_hit(paddr, ptm_pkg::OFS_VALUE) &&
            table_select == ptm_pkg::PTM_TBL_LUMINANCE) begin
            table_mem[table_entry_index] <= pwdata[9:0];
        end
    end

    // ------------------------------------------------------------
    // Pixel pipeline
    // ------------------------------------------------------------
    logic                    advance;
    logic                    s1_valid;
    logic [9:0]              s1_pix;
    logic                    s2_valid;
    logic [7:0]              s2_pix;
    logic                    s3_valid;
    logic [7:0]              s3_pix;
    logic                    buf_full;
    logic [9:0]              lo_entry;
    logic [9:0]              hi_entry;
    logic [10:0]             pair_sum;
    logic [9:0]              mapped;
    logic [7:0]              next_s2_pix;

    // All stages step together; the buffer always has room for the last stage
    assign advance      = !buf_full;
    assign pix_in_ready = advance;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_valid <= 1'b0;
            s2_valid <= 1'b0;
            s3_valid <= 1'b0;
        end else if (advance) begin
            s1_valid <= pix_in_valid;
            s2_valid <= s1_valid;
            s3_valid <= s2_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_pix <= 10'h000;
        end else if (advance && pix_in_valid) begin
            s1_pix <= pix_in_data;
        end
    end

    assign lo_entry = table_mem[{s1_pix[9:1], 1'b0}];
    // Top odd pixel would wrap here; its result is overridden below
    assign hi_entry = table_mem[{s1_pix[9:1] + 9'h001, 1'b0}];
    assign pair_sum = {1'b0, lo_entry} + {1'b0, hi_entry};

    always_comb begin
        mapped = lo_entry;
        if (s1_pix == ptm_pkg::PIX_TOP) begin
            // top pixel uses last even entry
            mapped = table_mem[ptm_pkg::PIX_LAST_EVEN];
        end else if (s1_pix[0]) begin
            mapped = pair_sum[10:1];
        end
        if (map_enable) begin
            next_s2_pix = mapped[9:2];
        end else begin
            next_s2_pix = s1_pix[9:2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s2_pix <= 8'h00;
        end else if (advance && s1_valid) begin
            s2_pix <= next_s2_pix;
        end
    end

    // ------------------------------------------------------------
    // Tone correction
    // ------------------------------------------------------------
    // Log and exp are piecewise linear; midrange values carry a few
    // codes of error, traded for a single-cycle stage with no tables
    logic [9:0]              log_in;
    logic [9:0]              log_dist;
    logic [21:0]             log_prod;
    logic [11:0]             exp_arg;
    logic [4:0]              exp_int;
    logic [6:0]              exp_frac;
    logic [16:0]             mant;
    logic [7:0]              tone_out;
    logic [7:0]              next_s3_pix;

    assign log_in   = log2_q(s2_pix);
    assign log_dist = ptm_pkg::LOG_Y_MAX - log_in;
    assign log_prod = {12'h000, log_dist} * {10'h000, tone_exponent};
    assign exp_arg  = log_prod[21:10];
    assign exp_int  = exp_arg[11:7];
    assign exp_frac = exp_arg[6:0];
    assign mant     = 17'(ptm_pkg::Y_MAX_8) * {8'h00, 9'h100 - {2'b00, exp_frac}};

    // ceiling times ratio to the exponent
    always_comb begin
        if (exp_int > 5'd8) begin
            tone_out = 8'h00;
        end else begin
            tone_out = 8'(mant >> (5'd8 + exp_int));
        end
        if (!tone_enable) begin
            next_s3_pix = s2_pix;
        end else if (tone_exponent == ptm_pkg::EXP_ONE) begin
            next_s3_pix = s2_pix;
        end else if (s2_pix == 8'h00 || s2_pix == ptm_pkg::Y_MAX_8) begin
            next_s3_pix = s2_pix;
        end else begin
            next_s3_pix = tone_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s3_pix <= 8'h00;
        end else if (advance && s2_valid) begin
            s3_pix <= next_s3_pix;
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    logic [7:0]              buf_mem [ptm_pkg::BUF_DEPTH];
    logic                    buf_wptr;
    logic                    buf_rptr;
    logic [1:0]              buf_fill;
    logic                    buf_push;
    logic                    buf_pop;

    assign buf_full      = (buf_fill == 2'(ptm_pkg::BUF_DEPTH));
    assign buf_push      = advance && s3_valid;
    assign buf_pop       = pix_out_valid && pix_out_ready;
    assign pix_out_valid = (buf_fill != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_wptr <= 1'b0;
            buf_rptr <= 1'b0;
            buf_fill <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_wptr <= !buf_wptr;
            end
            if (buf_pop) begin
                buf_rptr <= !buf_rptr;
            end
            buf_fill <= buf_fill + 2'(buf_push) - 2'(buf_pop);
        end
    end

    always_ff @(posedge pclk) begin
        if (buf_push) begin
            buf_mem[buf_wptr] <= s3_pix;
        end
    end

    // Output data from the buffer storage flip-flops
    assign pix_out_data = buf_mem[buf_rptr];

    // ------------------------------------------------------------
    // Pixel counter and read data
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_count <= 32'h0000_0000;
        end else if (buf_pop) begin
            pixel_count <= pixel_count + 32'h0000_0001;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_access && !pwrite) begin
            case (paddr)
                ptm_pkg::OFS_CTRL: begin
                    prdata[ptm_pkg::CTRL_MAP_EN]  = map_enable;
                    prdata[ptm_pkg::CTRL_TONE_EN] = tone_enable;
                end
                ptm_pkg::OFS_SELECT: begin
                    prdata[1:0] = table_select;
                end
                ptm_pkg::OFS_INDEX: begin
                    prdata[9:0] = table_entry_index;
                end
                ptm_pkg::OFS_VALUE: begin
                    prdata[9:0] = table_mem[table_entry_index];
                end
                ptm_pkg::OFS_EXPONENT: begin
                    prdata[11:0] = tone_exponent;
                end
                ptm_pkg::OFS_STATUS: begin
                    prdata[ptm_pkg::STAT_FILL_LO +: 2] = buf_fill;
                    prdata[ptm_pkg::STAT_PIPE_LO +: 3] = {s3_valid, s2_valid, s1_valid};
                end
                ptm_pkg::OFS_COUNT: begin
                    prdata = pixel_count;
                end
                default: begin
                    prdata = 32'h0000_0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> inc/ptm_pkg.sv
// Constants and types shared by the pixel tone mapper
package ptm_pkg;
    // ------------------------------------------------------------
    // Pixel and table geometry
    // ------------------------------------------------------------
    localparam int          RAW_W        = 10;
    localparam int          OUT_W        = 8;
    localparam int          TBL_DEPTH    = 1024;
    localparam int          TBL_AW       = 10;
    localparam logic [9:0]  PIX_TOP      = 10'h3FF;
    localparam logic [9:0]  PIX_LAST_EVEN = 10'h3FE;
    // Brightness ceilings for the two output widths
    localparam logic [7:0]  Y_MAX_8      = 8'hFF;
    localparam logic [11:0] Y_MAX_12     = 12'hFFF;
    // Log2 of the 8 bit ceiling in the Q3.7 domain used by the gamma stage
    localparam logic [9:0]  LOG_Y_MAX    = 10'h3FF;

    // ------------------------------------------------------------
    // Exponent format: unsigned Q2.10, 0 to 3.99902
    // ------------------------------------------------------------
    localparam int          EXP_W        = 12;
    localparam int          EXP_FRAC     = 10;
    localparam logic [11:0] EXP_ONE      = 12'h400;
    localparam logic [11:0] EXP_RESET    = 12'h400;

    // ------------------------------------------------------------
    // APB register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_SELECT   = 8'h04;
    localparam logic [7:0]  OFS_INDEX    = 8'h08;
    localparam logic [7:0]  OFS_VALUE    = 8'h0C;
    localparam logic [7:0]  OFS_EXPONENT = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [7:0]  OFS_COUNT    = 8'h18;

    // Control register fields
    localparam int          CTRL_MAP_EN  = 0;
    localparam int          CTRL_TONE_EN = 1;
    // Status register fields
    localparam int          STAT_FILL_LO = 0;
    localparam int          STAT_PIPE_LO = 4;

    // Table selector codes
    typedef enum logic [1:0] {
        PTM_TBL_LUMINANCE = 2'h0
    } ptm_table_t;
    localparam ptm_table_t  SELECT_RESET = PTM_TBL_LUMINANCE;

    // Output buffer
    localparam int          BUF_DEPTH    = 2;
endpackage

// >>> dv/ptm_checker.sv
// Port-level assertions for the pixel tone mapper
`timescale 1ns/1ns
`default_nettype none
module ptm_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pix_in_valid,
    input wire logic        pix_in_ready,
    input wire logic [9:0]  pix_in_data,
    input wire logic        pix_out_valid,
    input wire logic        pix_out_ready,
    input wire logic [7:0]  pix_out_data
);
    // ------------------------------------------------------------
    // Mirrors of the settings, tracked from the bus
    // ------------------------------------------------------------
    logic        acc;
    logic        rd;
    logic        take;
    logic        bad;
    logic [1:0]  ctrl_m;
    logic [11:0] exp_m;
    logic [9:0]  d1, d2, d3, d4;
    logic [2:0]  inflight;
    assign acc  = psel && penable;
    assign rd   = acc && !pwrite;
    assign take = pix_in_valid && pix_in_ready;
    assign bad  = paddr > ptm_pkg::OFS_COUNT || paddr[1:0] != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_m <= 2'h0;
            exp_m  <= ptm_pkg::EXP_RESET;
        end else if (acc && pwrite && paddr == ptm_pkg::OFS_CTRL) begin
            ctrl_m <= pwdata[1:0];
        end else if (acc && pwrite && paddr == ptm_pkg::OFS_EXPONENT) begin
            exp_m  <= pwdata[11:0];
        end
    end
    // Pixels taken but not yet delivered; the raw check needs an empty path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inflight <= 3'h0;
        end else begin
            inflight <= inflight + 3'(take) - 3'(pix_out_valid && pix_out_ready);
        end
    end
    // Raw samples delayed by the four edges from take to output
    always_ff @(posedge pclk) begin
        d1 <= pix_in_data;
        d2 <= d1;
        d3 <= d2;
        d4 <= d3;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc |-> pslverr == bad)
        else $error("pslverr does not match the address map");
    a_select_luma: assert property (rd && paddr == ptm_pkg::OFS_SELECT |-> prdata == 32'h0)
        else $error("selector holds a non-luminance code");
    a_ctrl_back: assert property (rd && paddr == ptm_pkg::OFS_CTRL |-> prdata == {30'h0, ctrl_m})
        else $error("enable bits read back wrong");
    a_exp_back: assert property (rd && paddr == ptm_pkg::OFS_EXPONENT |-> prdata == {20'h0, exp_m})
        else $error("exponent read back wrong");
    a_raw_path: assert property (take && inflight == 3'h0 && ctrl_m == 2'h0
        |-> ##4 pix_out_valid && pix_out_data == d4[9:2])
        else $error("raw pixel late or not truncated");
    a_hold_stall: assert property (pix_out_valid && !pix_out_ready
        |=> pix_out_valid && $stable(pix_out_data))
        else $error("output changed while stalled");
    a_full_refuse: assert property ((pix_in_valid && !pix_out_ready) [*6] |-> !pix_in_ready)
        else $error("input still ready with full buffer");
endmodule
`default_nettype wire

// >>> dv/ptm_sensor.sv
// Sensor ADC model that feeds raw pixels to the mapper
`timescale 1ns/1ns
`default_nettype none
module ptm_sensor (
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  slow,
    input  wire logic  pix_in_ready,
    output logic       pix_in_valid,
    output logic [9:0] pix_in_data
);
    logic [9:0] pend_q[$];
    logic       rest;
    function automatic void push(input logic [9:0] v);
        pend_q.push_back(v);
    endfunction
    // Idle data flips every cycle so a stale sample never passes for a new one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_in_valid <= 1'b0;
            pix_in_data  <= 10'h155;
            rest         <= 1'b0;
        end else if (!pix_in_valid || pix_in_ready) begin
            if (pend_q.size() > 0 && !rest) begin
                pix_in_valid <= 1'b1;
                pix_in_data  <= pend_q.pop_front();
                rest         <= slow;
            end else begin
                pix_in_valid <= 1'b0;
                pix_in_data  <= ~pix_in_data;
                rest         <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/ptm_top_test.sv
// Self-checking bench for the pixel tone mapper
`timescale 1ns/1ns
`default_nettype none
module ptm_top_test;
    logic        pclk, presetn, psel, penable, pwrite, slow, pix_out_ready;
    logic        pready, pslverr, pix_in_valid, pix_in_ready, pix_out_valid;
    logic [7:0]  paddr, pix_out_data, exp_q[$], got_q[$];
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  pix_in_data, tbl [1024];
    int          miscompares, num_checks, cyc, total;
    always #5 pclk = ~pclk;
    ptm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
        .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
        .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data));
    ptm_sensor src (.pclk(pclk), .presetn(presetn), .slow(slow),
        .pix_in_ready(pix_in_ready), .pix_in_valid(pix_in_valid), .pix_in_data(pix_in_data));
    // ------------------------------------------------------------
    // Downstream sink: stalls half the time to fill the buffer
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        pix_out_ready <= (cyc % 16) < 8;
    end
    always @(negedge pclk)
        if (pix_out_valid && pix_out_ready) got_q.push_back(pix_out_data);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            print_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic px(input logic [9:0] p, input logic [7:0] e);
        src.push(p);
        exp_q.push_back(e);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (got_q.size() < exp_q.size() && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (got_q.size() < exp_q.size()) begin
            miscompares++;
            print_verdict();
        end
        total += exp_q.size();
        while (exp_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
        repeat (4) @(posedge pclk);
    endtask
    // Expected mapped pixel: even index direct, odd the floored midpoint
    function automatic logic [7:0] mapped(input int p);
        logic [10:0] s;
        if (p == 1023) s = {tbl[1022], 1'b0};
        else if (p % 2 == 0) s = {tbl[p], 1'b0};
        else s = tbl[p-1] + tbl[p+1];
        return s[10:3];
    endfunction
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ptm_pkg::OFS_CTRL, 0); check(rd, 32'h0);
        apb(0, ptm_pkg::OFS_STATUS, 0); check(rd, 32'h0);
        apb(0, ptm_pkg::OFS_EXPONENT, 0); check(rd, 32'h0000_0400);
        apb(0, 8'h1C, 0); check(rd, 32'h0);
        apb(1, ptm_pkg::OFS_SELECT, 32'h1);
        apb(0, ptm_pkg::OFS_SELECT, 0); check(rd, 32'h0);
        // Gapped source with raw path; odd steps cover every low-bit pattern
        slow <= 1'b1;
        for (int i = 0; i < 1024; i += 37) px(i[9:0], i[9:2]);
        drain();
        slow <= 1'b0;
        // Table with odd slots poisoned and odd neighbour sums
        for (int i = 0; i < 1024; i++) begin
            tbl[i] = i[0] ? 10'h2AA : {i[1], i[9:1]};
            apb(1, ptm_pkg::OFS_INDEX, i);
            apb(1, ptm_pkg::OFS_VALUE, {22'h0, tbl[i]});
        end
        apb(1, ptm_pkg::OFS_INDEX, 1023);
        apb(0, ptm_pkg::OFS_VALUE, 0); check(rd, 32'h0000_02AA);
        apb(1, ptm_pkg::OFS_INDEX, 1022);
        apb(0, ptm_pkg::OFS_VALUE, 0); check(rd, 32'h0000_03FF);
        apb(1, ptm_pkg::OFS_CTRL, 32'h1);
        for (int p = 0; p < 1024; p++) px(p[9:0], mapped(p));
        drain();
        apb(1, ptm_pkg::OFS_CTRL, 32'h2);
        apb(1, ptm_pkg::OFS_EXPONENT, 32'h0000_0FFF);
        apb(0, ptm_pkg::OFS_EXPONENT, 0); check(rd, 32'h0000_0FFF);
        for (int i = 0; i < 4; i++) px(i[9:0], 8'h00);
        for (int i = 1020; i < 1024; i++) px(i[9:0], 8'hFF);
        drain();
        apb(1, ptm_pkg::OFS_EXPONENT, 32'h0000_0400);
        for (int i = 0; i < 1024; i += 29) px(i[9:0], i[9:2]);
        drain();
        apb(1, ptm_pkg::OFS_EXPONENT, 32'h0);
        px(10'h100, 8'hFF);
        px(10'h004, 8'hFF);
        drain();
        // Midrange 128 squared over the 255 ceiling gives 64
        apb(1, ptm_pkg::OFS_EXPONENT, 32'h0000_0800);
        px(10'h200, 8'h40);
        drain();
        apb(1, ptm_pkg::OFS_CTRL, 32'h0);
        px(10'h200, 8'h80);
        drain();
        apb(0, ptm_pkg::OFS_COUNT, 0); check(rd, total);
        print_verdict();
    end
endmodule
bind ptm_top ptm_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
    .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data));
`default_nettype wire
